// ### bench/flash_program_erase_protect_tb_top.sv
/*
 flash_program_erase_protect_tb_top: self-checking bench for the flash
 program/erase sequencer, driving the register port directly.
 assumes flash_seq_pkg is compiled first and the sequencer's assertions
 live inside the design; setup_cycles is shortened to 4 for simulation.
*/
`timescale 1ns/100ps
module flash_program_erase_protect_tb_top;
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] prot;
		logic [15:0] a;
		logic tst;
		logic hv;
	} case_t;
	logic clk, rst_n, wr, rd, test_high_voltage, wait_mode;
	logic [15:0] addr, array_addr;
	logic [7:0] wdata, rdata, protect_start_byte, array_data, d;
	logic program_select, erase_select, mass_select;
	logic high_voltage_enable, array_write;
	int fails, compares;
	case_t tbl [12];

	flash_program_erase_protect #(.setup_cycles(4))
		flash_program_erase_protect_inst (.clk(clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.protect_start_byte(protect_start_byte),
		.test_high_voltage(test_high_voltage), .wait_mode(wait_mode),
		.program_select(program_select), .erase_select(erase_select),
		.mass_select(mass_select),
		.high_voltage_enable(high_voltage_enable),
		.array_write(array_write), .array_addr(array_addr),
		.array_data(array_data));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("counts: compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic wait_ready;
		logic [7:0] s;
		for (int i = 0; i < 50; i++) begin
			rd_reg(flash_seq_pkg::status_addr, s);
			if (s[flash_seq_pkg::bit_latched] === 1'b1) return;
		end
		fails++;
		report_and_stop();
	endtask

	// select, protect read, latch address, setup wait, then ask for hv
	task automatic run_seq(input case_t c);
		logic [7:0] v;
		@(posedge clk);
		protect_start_byte <= c.prot;
		test_high_voltage <= c.tst;
		wr_reg(flash_seq_pkg::ctrl_addr, c.sel);
		rd_reg(flash_seq_pkg::protect_addr, v);
		check(v, c.prot);
		rd_reg(flash_seq_pkg::status_addr, v);
		check(v[flash_seq_pkg::bit_prot_read], 1'b1);
		wr_reg(c.a, 8'h5A);
		wait_ready();
		wr_reg(flash_seq_pkg::ctrl_addr, c.sel | 8'h08);
		@(posedge clk);
		#1 check(high_voltage_enable, c.hv);
		rd_reg(flash_seq_pkg::status_addr, v);
		check(v[flash_seq_pkg::bit_refused], !c.hv);
		check(v[flash_seq_pkg::bit_hv_active], c.hv);
	endtask

	// clear the selects first, then high voltage
	task automatic clear_all;
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h08);
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h00);
		@(posedge clk);
		#1 check({program_select, erase_select, mass_select,
			high_voltage_enable}, 4'h0);
	endtask

	initial begin
		fails = 0;
		compares = 0;
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		protect_start_byte = 8'hFF;
		test_high_voltage = 1'b0;
		wait_mode = 1'b0;
		tbl[0] = '{8'h02, 8'hFF, 16'hC040, 1'b0, 1'b1};
		tbl[1] = '{8'h02, 8'hFD, 16'hFF7E, 1'b0, 1'b0};
		tbl[2] = '{8'h02, 8'hFD, 16'hFDC0, 1'b0, 1'b1};
		tbl[3] = '{8'h02, 8'hFE, 16'hFFDC, 1'b0, 1'b0};
		tbl[4] = '{8'h02, 8'hFE, 16'hFF7E, 1'b0, 1'b1};
		tbl[5] = '{8'h02, 8'h00, 16'hC000, 1'b0, 1'b0};
		tbl[6] = '{8'h02, 8'h00, 16'hC000, 1'b1, 1'b1};
		tbl[7] = '{8'h02, 8'h01, 16'hC000, 1'b0, 1'b1};
		tbl[8] = '{8'h02, 8'h01, 16'hC040, 1'b0, 1'b0};
		tbl[9] = '{8'h06, 8'hFE, 16'hC000, 1'b0, 1'b0};
		tbl[10] = '{8'h06, 8'hFF, 16'hD123, 1'b0, 1'b1};
		tbl[11] = '{8'h06, 8'hFE, 16'hC000, 1'b1, 1'b1};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 check({program_select, erase_select, mass_select,
			high_voltage_enable, array_write}, 5'h00);
		$display("reset test done");
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h02);
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h0A);
		@(posedge clk);
		#1 check(high_voltage_enable, 1'b0);
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h03);
		@(posedge clk);
		#1 check({program_select, erase_select}, 2'b01);
		clear_all();
		wr_reg(flash_seq_pkg::ctrl_addr, 8'h03);
		@(posedge clk);
		#1 check(program_select & erase_select, 1'b0);
		clear_all();
		$display("interlock test done");
		for (int i = 0; i < 12; i++) begin
			run_seq(tbl[i]);
			clear_all();
		end
		$display("protection test done");
		run_seq('{8'h01, 8'hFF, 16'hC000, 1'b0, 1'b1});
		wr_reg(16'hC001, 8'hA5);
		#1 check(array_write, 1'b1);
		check({array_addr, array_data}, {16'hC001, 8'hA5});
		wr_reg(16'hC01F, 8'h3C);
		#1 check({array_write, array_addr}, {1'b1, 16'hC01F});
		wr_reg(16'hC020, 8'h00);
		#1 check(array_write, 1'b0);
		rd_reg(flash_seq_pkg::status_addr, d);
		check(d[flash_seq_pkg::bit_row_fail], 1'b1);
		@(posedge clk);
		wait_mode <= 1'b1;
		@(posedge clk);
		wait_mode <= 1'b0;
		@(posedge clk);
		#1 check({program_select, erase_select, mass_select,
			high_voltage_enable}, 4'h0);
		$display("program test done");
		report_and_stop();
	end
endmodule // flash_program_erase_protect_tb_top

// ### inc/flash_seq_pkg.sv
/*
 flash_seq_pkg: register offsets, control bit positions, address layout and
 timing constants of the flash program/erase sequencer.
 assumes a 16-bit cpu address space with the array in its top quarter.
*/
package flash_seq_pkg;
	// register port offsets (byte addresses on the plain register port)
	localparam logic [15:0] ctrl_addr = 16'hFE08;
	localparam logic [15:0] protect_addr = 16'hFF7E;
	localparam logic [15:0] status_addr = 16'hFE09;
	localparam logic [15:0] array_lo = 16'hC000;
	localparam logic [15:0] user_hi = 16'hFDFF;
	localparam logic [15:0] vect_lo = 16'hFFDC;
	localparam logic [15:0] vect_hi = 16'hFFFF;
	// control register bit positions
	localparam int bit_pgm = 0;
	localparam int bit_erase = 1;
	localparam int bit_mass = 2;
	localparam int bit_high_voltage_enable = 3;
	// status register bit positions
	localparam int bit_latched = 0;
	localparam int bit_prot_read = 1;
	localparam int bit_hv_active = 2;
	localparam int bit_row_fail = 3;
	localparam int bit_refused = 4;
	// address layout
	localparam int page_lsb = 6;
	localparam int row_lsb = 5;
	localparam logic [1:0] prot_top = 2'h3;
	localparam logic [5:0] prot_low = 6'h00;
	localparam logic [7:0] prot_open = 8'hFF;
	localparam logic [7:0] prot_vect_only = 8'hFE;
	localparam logic [7:0] prot_reset = 8'hFF;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// timing
	localparam int clk_mhz = 40;
	localparam int setup_delay_us = 10;
	localparam int setup_delay_cyc = setup_delay_us * clk_mhz;
	localparam int page_bytes = 64;
	localparam int vector_bytes = 36;
	localparam int row_bytes = 32;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_armed = 3'b001,
		st_latched = 3'b010,
		st_ready = 3'b011,
		st_hv = 3'b100
	} seq_state_t;
endpackage

// ### rtl/flash_program_erase_protect.sv
/*
 flash_program_erase_protect: control sequencer for page erase, mass erase
 and row programming of an on-chip flash, with block protection.
 assumes a single-clock cpu register port; the array itself, charge pump and
 protect byte storage sit outside and are driven from the outputs here.
 // How it works
 // (R01) page erase covers 64 aligned bytes; vector area erases as one page
 // (R02) page erase: select erase, read protect, write page, wait, set hv
 // (R03) after hv, software holds, clears erase, waits, then clears hv
 // (R04) long erase hold advised above a thousand cycles
 // (R05) mass erase adds whole-array select and longer hold times
 // (R06) mass erase is refused unless protect byte is all ones
 // (R07) programming stays in one 32-byte row, else the attempt fails
 // (R08) software programs only erased bytes
 // (R09) program select enables address and data latching for a row
 // (R10) each byte written under hv, then software waits
 // (R11) byte intervals never exceed the per-byte maximum
 // (R12) cumulative hv time per row stays within its maximum
 // (R13) program routine runs outside the array
 // (R14) steps in order; unrelated bus traffic between steps is harmless
 // (R15) protected address blocks setting high voltage
 // (R16) protect byte read between select and high voltage
 // (R17) protect start is 11, protect byte, six zeros, up to top
 // (R18) all zeros protects everything; all ones protects nothing
 // (R19) protect byte other than open or vector-only locks itself
 // (R20) test high voltage on interrupt pin bypasses protection
 // (R21) protect byte erases like any byte when its page is open
 // (R22) wait mode aborts the operation and returns to standby
 // (R23) erase and program select never both one
 // (R24) hv set only with a select and the proper sequence done
*/
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module flash_program_erase_protect #(
	parameter int setup_cycles = flash_seq_pkg::setup_delay_cyc
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [7:0] protect_start_byte,
	input wire logic test_high_voltage,
	input wire logic wait_mode,
	output logic program_select,
	output logic erase_select,
	output logic mass_select,
	output logic high_voltage_enable,
	output logic array_write,
	output logic [15:0] array_addr,
	output logic [7:0] array_data
);
	localparam int cnt_w = $clog2(setup_cycles + 1);
	flash_seq_pkg::seq_state_t state_q;
	logic [7:0] rdata_q;
	logic [cnt_w-1:0] cnt_q;
	logic [15:0] latch_addr_q;
	logic [15:0] base_q;
	logic prot_read_q;
	logic row_fail_q;
	logic refused_q;
	logic awr_q;
	logic [7:0] adata_q;
	logic ctrl_wr;
	logic arr_wr;
	logic in_array;
	logic [15:0] prot_start;
	logic prot_bypass;
	logic addr_protected;
	logic protect_locked;
	logic mass_ok;
	logic hv_req;
	logic hv_allow;

	assign ctrl_wr = wr && (addr == flash_seq_pkg::ctrl_addr);
	assign in_array = ((addr >= flash_seq_pkg::array_lo) &&
		(addr <= flash_seq_pkg::user_hi)) || (addr ==
		flash_seq_pkg::protect_addr) || (addr >= flash_seq_pkg::vect_lo);
	assign arr_wr = wr && in_array;
	assign prot_start = {flash_seq_pkg::prot_top, protect_start_byte,
		flash_seq_pkg::prot_low}; // R17
	assign prot_bypass = test_high_voltage; // R20
	// all zeros gives the array base, all ones leaves nothing protected
	assign addr_protected = !prot_bypass &&
		(protect_start_byte != flash_seq_pkg::prot_open) &&
		(latch_addr_q >= prot_start); // R17 R18
	// a locked protect byte sits inside its own protected range
	assign protect_locked = (protect_start_byte != flash_seq_pkg::prot_open)
		&& (protect_start_byte != flash_seq_pkg::prot_vect_only); // R19
	assign mass_ok = prot_bypass ||
		(protect_start_byte == flash_seq_pkg::prot_open); // R06
	assign hv_req = ctrl_wr && wdata[flash_seq_pkg::bit_high_voltage_enable];
	assign hv_allow = (state_q == flash_seq_pkg::st_ready) &&
		(program_select || erase_select) &&
		!(mass_select ? !mass_ok : addr_protected) &&
		!(protect_locked && !prot_bypass &&
		(latch_addr_q == flash_seq_pkg::protect_addr)); // R15 R19 R21 R24

	// select bits; wait mode drops everything into standby
	always_ff @(posedge clk) begin
		if (!rst_n || wait_mode) begin // R22
			program_select <= 1'b0;
			erase_select <= 1'b0;
			mass_select <= 1'b0;
		end else if (ctrl_wr) begin
			mass_select <= wdata[flash_seq_pkg::bit_mass];
			// both set at once, or one while the other is on: refused
			if (!(wdata[flash_seq_pkg::bit_pgm] &&
				(wdata[flash_seq_pkg::bit_erase] || erase_select))) begin
				program_select <= wdata[flash_seq_pkg::bit_pgm]; // R23
			end
			if (!(wdata[flash_seq_pkg::bit_erase] &&
				(wdata[flash_seq_pkg::bit_pgm] || program_select))) begin
				erase_select <= wdata[flash_seq_pkg::bit_erase]; // R23
			end
		end
	end

	// sequence: select, protect read, latch write, setup wait, hv
	always_ff @(posedge clk) begin
		if (!rst_n || wait_mode) begin // R22
			state_q <= flash_seq_pkg::st_idle;
			cnt_q <= '0;
			prot_read_q <= 1'b0;
		end else begin
			case (state_q)
			flash_seq_pkg::st_idle: begin
				prot_read_q <= 1'b0;
				if (program_select || erase_select) begin
					state_q <= flash_seq_pkg::st_armed;
				end
			end
			flash_seq_pkg::st_armed: begin
				if (!(program_select || erase_select)) begin
					state_q <= flash_seq_pkg::st_idle;
				end else if (rd && addr == flash_seq_pkg::protect_addr) begin
					prot_read_q <= 1'b1; // R16
				end else if (arr_wr && prot_read_q) begin
					state_q <= flash_seq_pkg::st_latched; // R09
					cnt_q <= cnt_w'(setup_cycles);
				end
			end
			flash_seq_pkg::st_latched: begin
				// other bus traffic does not disturb the count
				if (!(program_select || erase_select)) begin // R14
					state_q <= flash_seq_pkg::st_idle;
				end else if (cnt_q <= cnt_w'(1)) begin
					state_q <= flash_seq_pkg::st_ready;
				end else begin
					cnt_q <= cnt_q - cnt_w'(1);
				end
			end
			flash_seq_pkg::st_ready: begin
				if (!(program_select || erase_select)) begin
					state_q <= flash_seq_pkg::st_idle;
				end else if (hv_req && hv_allow) begin
					state_q <= flash_seq_pkg::st_hv; // R24
				end
			end
			flash_seq_pkg::st_hv: begin
				if (!high_voltage_enable) begin
					state_q <= flash_seq_pkg::st_idle;
				end
			end
			default: state_q <= flash_seq_pkg::st_idle;
			endcase
		end
	end

	// high voltage: set only when allowed, cleared by software or abort
	always_ff @(posedge clk) begin
		if (!rst_n || wait_mode) begin // R22
			high_voltage_enable <= 1'b0;
		end else if (ctrl_wr) begin
			if (!wdata[flash_seq_pkg::bit_high_voltage_enable]) begin
				high_voltage_enable <= 1'b0;
			end else if (hv_allow || high_voltage_enable) begin
				high_voltage_enable <= 1'b1; // R15 R24
			end
		end
	end

	// refusal flag: hv denied, sticky until a control write with the hv bit clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
		end else if (hv_req && !hv_allow && !high_voltage_enable) begin
			refused_q <= 1'b1; // R06 R15
		end else if (ctrl_wr && !wdata[flash_seq_pkg::bit_high_voltage_enable]) begin
			refused_q <= 1'b0;
		end
	end

	// latched address and row guard
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch_addr_q <= '0;
			base_q <= '0;
			row_fail_q <= 1'b0;
		end else if (arr_wr && state_q == flash_seq_pkg::st_armed &&
			prot_read_q) begin
			latch_addr_q <= addr;
			row_fail_q <= 1'b0;
			// page granule for erase, row granule for programming
			if (erase_select) begin
				base_q <= {addr[15:flash_seq_pkg::page_lsb],
					{flash_seq_pkg::page_lsb{1'b0}}}; // R01
			end else begin
				base_q <= {addr[15:flash_seq_pkg::row_lsb],
					{flash_seq_pkg::row_lsb{1'b0}}}; // R07
			end
		end else if (arr_wr && state_q == flash_seq_pkg::st_hv &&
			program_select) begin
			if (addr[15:flash_seq_pkg::row_lsb] !=
				base_q[15:flash_seq_pkg::row_lsb]) begin
				row_fail_q <= 1'b1; // R07
			end
		end
	end

	// array strobe: byte program within the latched row only, never for erase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awr_q <= 1'b0;
			adata_q <= '0;
			array_addr <= '0;
		end else begin
			awr_q <= arr_wr && state_q == flash_seq_pkg::st_hv &&
				program_select && !row_fail_q &&
				(addr[15:flash_seq_pkg::row_lsb] ==
				base_q[15:flash_seq_pkg::row_lsb]); // R07 R10
			if (arr_wr) begin
				adata_q <= wdata;
				array_addr <= addr;
			end
		end
	end
	assign array_write = awr_q;
	assign array_data = adata_q;

	// register read port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= flash_seq_pkg::ctrl_reset;
		end else if (rd) begin
			if (addr == flash_seq_pkg::ctrl_addr) begin
				rdata_q <= {4'h0, high_voltage_enable, mass_select,
					erase_select, program_select};
			end else if (addr == flash_seq_pkg::status_addr) begin
				rdata_q <= {3'h0, refused_q, row_fail_q,
					(state_q == flash_seq_pkg::st_hv), prot_read_q,
					(state_q == flash_seq_pkg::st_ready)};
			end else if (addr == flash_seq_pkg::protect_addr) begin
				rdata_q <= protect_start_byte;
			end else begin
				rdata_q <= 8'h00;
			end
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata = rdata_q;

	// multi-step behaviours are built from these sequences
	sequence seq_hv_rise;
		!high_voltage_enable ##1 high_voltage_enable;
	endsequence
	sequence seq_latch_entry;
		state_q == flash_seq_pkg::st_armed ##1
		state_q == flash_seq_pkg::st_latched;
	endsequence
	sequence seq_bypass_ask;
		hv_req && test_high_voltage && !wait_mode &&
		state_q == flash_seq_pkg::st_ready &&
		(program_select || erase_select);
	endsequence

	AST_INTERLOCK: assert property ( // R23
		@(posedge clk) disable iff (!rst_n)
		!(program_select && erase_select))
		else $error("program and erase selects both set");
	AST_HV_NEEDS_SEL: assert property ( // R24
		@(posedge clk) disable iff (!rst_n)
		$rose(high_voltage_enable) |-> $past(program_select) ||
		$past(erase_select))
		else $error("hv rose without a select");
	AST_MASS_REFUSE: assert property ( // R06
		@(posedge clk) disable iff (!rst_n)
		$rose(high_voltage_enable) && mass_select |->
		$past(protect_start_byte) == flash_seq_pkg::prot_open ||
		$past(test_high_voltage))
		else $error("mass erase allowed while protected");
	AST_PROTECT: assert property ( // R15
		@(posedge clk) disable iff (!rst_n)
		hv_req && addr_protected && !mass_select |=>
		!$rose(high_voltage_enable))
		else $error("hv set on protected address");
	AST_LOCK_SELF: assert property ( // R19
		@(posedge clk) disable iff (!rst_n)
		hv_req && protect_locked && !test_high_voltage &&
		latch_addr_q == flash_seq_pkg::protect_addr |=>
		!$rose(high_voltage_enable))
		else $error("hv set on a locked protect byte");
	AST_BYPASS: assert property ( // R20
		@(posedge clk) disable iff (!rst_n)
		seq_bypass_ask |=> high_voltage_enable)
		else $error("test voltage did not bypass protection");
	AST_WAIT_ABORT: assert property ( // R22
		@(posedge clk) disable iff (!rst_n)
		wait_mode |=> !high_voltage_enable && !program_select &&
		!erase_select && state_q == flash_seq_pkg::st_idle)
		else $error("wait mode did not abort");
	AST_PROT_READ: assert property ( // R16
		@(posedge clk) disable iff (!rst_n)
		state_q == flash_seq_pkg::st_ready |-> prot_read_q)
		else $error("ready without protect read");
	AST_LATCH_ORDER: assert property ( // R09
		@(posedge clk) disable iff (!rst_n)
		seq_latch_entry |-> prot_read_q && latch_addr_q == $past(addr))
		else $error("address latched out of order");
	AST_SETUP_HOLD: assert property ( // R24
		@(posedge clk) disable iff (!rst_n)
		state_q == flash_seq_pkg::st_latched && cnt_q > cnt_w'(1) &&
		!wait_mode |=> state_q != flash_seq_pkg::st_ready)
		else $error("setup wait cut short");
	AST_HV_FROM_READY: assert property ( // R24
		@(posedge clk) disable iff (!rst_n)
		seq_hv_rise |-> state_q == flash_seq_pkg::st_hv)
		else $error("hv rose outside the hv state");
	AST_STROBE_PGM: assert property ( // R10
		@(posedge clk) disable iff (!rst_n)
		array_write |-> $past(program_select))
		else $error("array strobe without program select");
	AST_ROW_FAIL: assert property ( // R07
		@(posedge clk) disable iff (!rst_n)
		array_write |-> array_addr[15:flash_seq_pkg::row_lsb] ==
		base_q[15:flash_seq_pkg::row_lsb])
		else $error("program strobe outside row");
	AST_PROT_START: assert property ( // R18
		@(posedge clk) disable iff (!rst_n)
		protect_start_byte == 8'h00 && !test_high_voltage |->
		prot_start == flash_seq_pkg::array_lo)
		else $error("all-zero protect does not cover array");
	AST_ZERO_START: assert property ( // R17
		@(posedge clk) disable iff (!rst_n)
		prot_start[5:0] == flash_seq_pkg::prot_low &&
		prot_start[15:14] == flash_seq_pkg::prot_top)
		else $error("protect start address malformed");
endmodule // flash_program_erase_protect
